// file: core/request_map.vh
`ifndef REQUEST_MAP_VH
`define REQUEST_MAP_VH
// request line and channel counts
`define NUM_LINES        32
`define NUM_CHANNELS     16
`define LINE_IDX_W       5
// fixed line positions of dedicated sources
`define LINE_BSP1_RX     5'h00
`define LINE_BSP1_TX     5'h01
`define LINE_BSP3_RX     5'h0e
`define LINE_BSP3_TX     5'h0f
`define LINE_BSP5_RX     5'h1e
`define LINE_BSP5_TX     5'h1f
`endif

// file: core/request_or_merge.v
`timescale 1ns/1ps
// ORs the source groups feeding the 32 request lines; each input vector holds
// one bit per line, zero where that kind of source does not reach the line
module request_or_merge (
  input  wire [31:0] bsp1_req,
  input  wire [31:0] bsp3_req,
  input  wire [31:0] bsp5_req,
  input  wire [31:0] misc_req,
  output wire [31:0] line_req
);
  assign line_req = bsp1_req | bsp3_req | bsp5_req | misc_req;
endmodule // request_or_merge

// file: core/channel_assign.v
`timescale 1ns/1ps
`include "request_map.vh"
// one channel's request select; reset value equals its own index
module channel_assign #(
  parameter [4:0] CHAN_IDX = 5'h00
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [4:0]  wr_line,
  input  wire [31:0] line_req,
  output reg         chan_req,
  output wire [4:0]  sel
);
  reg [4:0] sel_reg;
  reg       loaded_reg;
  assign sel = sel_reg;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg    <= CHAN_IDX;
      loaded_reg <= 1'b0;
    end else if (wr_en) begin
      sel_reg    <= wr_line;
      loaded_reg <= 1'b1;
    end else if (!loaded_reg) begin
      sel_reg    <= CHAN_IDX;
      loaded_reg <= 1'b1;
    end
  end
  // until the first edge after reset the index is selected directly
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_req <= 1'b0;
    end else begin
      chan_req <= line_req[loaded_reg ? sel_reg : CHAN_IDX];
    end
  end
endmodule // channel_assign

// file: core/dma_request_line_mapper.v
`timescale 1ns/1ps
`include "request_map.vh"
module dma_request_line_mapper (
  input  wire        mclk,
  input  wire        rst_n,
  // buffered serial ports: bit k is buffer k request; [1]/[0] are plain-mode rx/tx
  input  wire [15:0] buffered_serial_port_one,
  input  wire [15:0] buffered_serial_port_three,
  input  wire [15:0] buffered_serial_port_five,
  input  wire [1:0]  plain_serial_port_two,
  input  wire [1:0]  plain_serial_port_four,
  input  wire        converter_one_event,
  input  wire        converter_one_group_one,
  input  wire        converter_one_group_two,
  input  wire        converter_two_event,
  input  wire        converter_two_group_one,
  input  wire        converter_two_group_two,
  input  wire [1:0]  i2c_req,
  input  wire        can_controller_one_message_interface_one,
  input  wire        can_controller_one_message_interface_two,
  input  wire        can_controller_one_message_interface_three,
  input  wire        can_controller_two_message_interface_one,
  input  wire        can_controller_two_message_interface_two,
  input  wire        can_controller_two_message_interface_three,
  input  wire        can_controller_three_message_interface_one,
  input  wire        can_controller_three_message_interface_two,
  input  wire        can_controller_three_message_interface_three,
  input  wire [3:0]  os_tick_timer,
  input  wire [7:4]  high_end_timer_one,
  input  wire [7:4]  high_end_timer_two,
  input  wire [1:0]  crc_req,
  input  wire [1:0]  lin_req,
  input  wire [1:0]  async_serial_port,
  // channel assignment write port
  input  wire        assign_wr,
  input  wire [3:0]  assign_chan,
  input  wire [4:0]  assign_line,
  output wire [31:0] periph_transfer_request_line,
  output wire [15:0] channel_request,
  output wire [79:0] request_channel_assign_regs
);
  wire [31:0] bsp1_v;
  wire [31:0] bsp3_v;
  wire [31:0] bsp5_v;
  wire [31:0] misc_v;
  wire [31:0] line_req;

  // placement of buffers follows the shared-line table
  assign bsp1_v = {b(buffered_serial_port_one,15), b(buffered_serial_port_one,14),
                   2'b00, b(buffered_serial_port_one,13), b(buffered_serial_port_one,12), 2'b00,
                   b(buffered_serial_port_one,11), b(buffered_serial_port_one,10), 4'h0,
                   b(buffered_serial_port_one,9), b(buffered_serial_port_one,8), 2'b00,
                   b(buffered_serial_port_one,7), b(buffered_serial_port_one,6), 2'b00,
                   b(buffered_serial_port_one,5), b(buffered_serial_port_one,4), 2'b00,
                   b(buffered_serial_port_one,3), b(buffered_serial_port_one,2), 2'b00,
                   b(buffered_serial_port_one,0), b(buffered_serial_port_one,1)};
  assign bsp3_v = {b(buffered_serial_port_three,15), b(buffered_serial_port_three,14),
                   2'b00, b(buffered_serial_port_three,13), b(buffered_serial_port_three,12), 2'b00,
                   b(buffered_serial_port_three,11), b(buffered_serial_port_three,10), 4'h0,
                   b(buffered_serial_port_three,9), b(buffered_serial_port_three,8),
                   b(buffered_serial_port_three,0), b(buffered_serial_port_three,1),
                   b(buffered_serial_port_three,7), b(buffered_serial_port_three,6), 2'b00,
                   b(buffered_serial_port_three,5), b(buffered_serial_port_three,4), 2'b00,
                   b(buffered_serial_port_three,3), b(buffered_serial_port_three,2), 4'h0};
  assign bsp5_v = {b(buffered_serial_port_five,0), b(buffered_serial_port_five,1),
                   b(buffered_serial_port_five,15), b(buffered_serial_port_five,14), 2'b00,
                   b(buffered_serial_port_five,13), b(buffered_serial_port_five,12),
                   b(buffered_serial_port_five,11), b(buffered_serial_port_five,10), 2'b00,
                   b(buffered_serial_port_five,9), b(buffered_serial_port_five,8), 2'b00,
                   b(buffered_serial_port_five,7), b(buffered_serial_port_five,6), 2'b00,
                   b(buffered_serial_port_five,5), b(buffered_serial_port_five,4), 2'b00,
                   b(buffered_serial_port_five,3), b(buffered_serial_port_five,2), 6'h00};
  assign misc_v[0]  = 1'b0;
  assign misc_v[1]  = 1'b0;
  assign misc_v[2]  = plain_serial_port_two[0];
  assign misc_v[3]  = plain_serial_port_two[1];
  assign misc_v[4]  = can_controller_two_message_interface_three;
  assign misc_v[5]  = can_controller_two_message_interface_two;
  assign misc_v[6]  = can_controller_one_message_interface_two;
  assign misc_v[7]  = converter_one_event;
  assign misc_v[8]  = can_controller_one_message_interface_one;
  assign misc_v[9]  = can_controller_two_message_interface_one;
  assign misc_v[10] = converter_one_group_one | i2c_req[0];
  assign misc_v[11] = converter_one_group_two | i2c_req[1];
  assign misc_v[12] = os_tick_timer[0];
  assign misc_v[13] = os_tick_timer[1];
  assign misc_v[14] = converter_two_event;
  assign misc_v[15] = 1'b0;
  assign misc_v[16] = can_controller_one_message_interface_three | converter_two_group_one;
  assign misc_v[17] = can_controller_three_message_interface_one | converter_two_group_two;
  assign misc_v[18] = os_tick_timer[2];
  assign misc_v[19] = os_tick_timer[3];
  assign misc_v[20] = high_end_timer_one[4] | high_end_timer_two[4] |
                      can_controller_three_message_interface_two;
  assign misc_v[21] = high_end_timer_one[5] | high_end_timer_two[5] |
                      can_controller_three_message_interface_three;
  assign misc_v[22] = 1'b0;
  assign misc_v[23] = 1'b0;
  assign misc_v[24] = high_end_timer_one[6] | high_end_timer_two[6] | plain_serial_port_four[0];
  assign misc_v[25] = high_end_timer_one[7] | high_end_timer_two[7] | plain_serial_port_four[1];
  assign misc_v[26] = crc_req[0];
  assign misc_v[27] = crc_req[1];
  assign misc_v[28] = lin_req[0];
  assign misc_v[29] = lin_req[1];
  assign misc_v[30] = async_serial_port[0];
  assign misc_v[31] = async_serial_port[1];

  function b;
    input [15:0] v;
    input integer k;
    begin
      b = v[k];
    end
  endfunction

  // plain OR: with several enabled sources the line just merges them
  request_or_merge u_merge (
    .bsp1_req (bsp1_v),
    .bsp3_req (bsp3_v),
    .bsp5_req (bsp5_v),
    .misc_req (misc_v),
    .line_req (line_req)
  );

  assign periph_transfer_request_line = line_req;

  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : g_chan
      channel_assign #(.CHAN_IDX(g[4:0])) u_chan (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .wr_en    (assign_wr && (assign_chan == g[3:0])),
        .wr_line  (assign_line),
        .line_req (line_req),
        .chan_req (channel_request[g]),
        .sel      (request_channel_assign_regs[g*5 +: 5])
      );
    end
  endgenerate
endmodule // dma_request_line_mapper

// file: bench/mapper_monitor.sv
`timescale 1ns/1ps
module mapper_monitor (
  input wire        mclk,
  input wire        rst_n,
  input wire        assign_wr,
  input wire [3:0]  assign_chan,
  input wire [4:0]  assign_line,
  input wire [15:0] buffered_serial_port_one,
  input wire [3:0]  os_tick_timer,
  input wire [1:0]  crc_req,
  input wire [1:0]  lin_req,
  input wire [31:0] periph_transfer_request_line,
  input wire [15:0] channel_request,
  input wire [79:0] request_channel_assign_regs
);
  wire [31:0] ln = periph_transfer_request_line;
  wire [79:0] rg = request_channel_assign_regs;
  reg  [15:0] sel_req;
  integer     k;
  always @* begin
    for (k = 0; k < 16; k = k + 1)
      sel_req[k] = ln[rg[5*k +: 5]];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    assign_wr;
  endsequence
  AST_WR_LOAD: assert property (s_wr |=> rg[$past(assign_chan)*5 +: 5] == $past(assign_line))
    else $error("select not loaded");
  AST_HOLD: assert property (!assign_wr && !$rose(rst_n) |=> $stable(rg))
    else $error("select changed without write");
  AST_DEFAULT: assert property ($rose(rst_n) && !assign_wr |=> rg == 80'h7b9ac5a928398a418820)
    else $error("default map wrong");
  // the edge that leaves reset still shows the cleared channel_request
  AST_FOLLOW: assert property ($past(rst_n) |-> channel_request == $past(sel_req))
    else $error("channel request wrong");
  AST_LINE0: assert property (ln[0] == buffered_serial_port_one[1]) else $error("line 0 wrong");
  AST_LINE1: assert property (ln[1] == buffered_serial_port_one[0]) else $error("line 1 wrong");
  AST_TICK: assert property (os_tick_timer[2] |-> ln[18]) else $error("line 18 low");
  AST_CRC: assert property (crc_req[0] |-> ln[26]) else $error("line 26 low");
  AST_LIN: assert property (lin_req[1] |-> ln[29]) else $error("line 29 low");
endmodule // mapper_monitor
bind dma_request_line_mapper mapper_monitor mapper_monitor_inst (.mclk, .rst_n, .assign_wr, .assign_chan,
  .assign_line, .buffered_serial_port_one, .os_tick_timer, .crc_req, .lin_req, .periph_transfer_request_line,
  .channel_request, .request_channel_assign_regs);

// file: bench/request_sources.sv
`timescale 1ns/1ps
module request_sources (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        en,
  input  wire [6:0]  idx,
  output reg  [86:0] src
);
  // one source at a time, since shared lines cannot tell sources apart
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) src <= 87'h0;
    else src <= en ? (87'h1 << idx) : 87'h0;
  end
endmodule // request_sources

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         mclk, rst_n, en, assign_wr;
  reg  [6:0]  idx;
  reg  [3:0]  assign_chan;
  reg  [4:0]  assign_line;
  reg  [31:0] r;
  reg  [4:0]  m [0:15];
  wire [86:0] s;
  wire [31:0] ln;
  wire [15:0] cr;
  wire [79:0] rg;
  integer     n_errors, total_checks, seed, i, j;
  string      tbl = "104589<=@AFGJKNO?>4589<=@AFGJKNOON67:;>?BCFGHILM23HI7:;>@A:;86@954ADE<=BCDEHIDEHIJKLMNO";
  request_sources request_sources_inst (.mclk(mclk), .rst_n(rst_n), .en(en), .idx(idx), .src(s));
  dma_request_line_mapper dma_request_line_mapper_inst (.mclk(mclk), .rst_n(rst_n),
    .buffered_serial_port_one(s[15:0]), .buffered_serial_port_three(s[31:16]), .buffered_serial_port_five(s[47:32]),
    .plain_serial_port_two(s[49:48]), .plain_serial_port_four(s[51:50]), .converter_one_event(s[52]),
    .converter_one_group_one(s[53]), .converter_one_group_two(s[54]), .converter_two_event(s[55]),
    .converter_two_group_one(s[56]), .converter_two_group_two(s[57]), .i2c_req(s[59:58]),
    .can_controller_one_message_interface_one(s[60]), .can_controller_one_message_interface_two(s[61]),
    .can_controller_one_message_interface_three(s[62]), .can_controller_two_message_interface_one(s[63]),
    .can_controller_two_message_interface_two(s[64]), .can_controller_two_message_interface_three(s[65]),
    .can_controller_three_message_interface_one(s[66]), .can_controller_three_message_interface_two(s[67]),
    .can_controller_three_message_interface_three(s[68]), .os_tick_timer(s[72:69]),
    .high_end_timer_one(s[76:73]), .high_end_timer_two(s[80:77]), .crc_req(s[82:81]), .lin_req(s[84:83]),
    .async_serial_port(s[86:85]), .assign_wr(assign_wr), .assign_chan(assign_chan), .assign_line(assign_line),
    .periph_transfer_request_line(ln), .channel_request(cr), .request_channel_assign_regs(rg));
  function automatic logic [79:0] exp_regs();
    for (int c = 0; c < 16; c++)
      exp_regs[5*c +: 5] = m[c];
  endfunction
  function automatic logic [15:0] exp_chan(input logic [31:0] l);
    for (int c = 0; c < 16; c++)
      exp_chan[c] = l[m[c]];
  endfunction
  task chk(input logic [79:0] seen, input logic [79:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task probe(input logic [6:0] k);
    logic [31:0] l;
    l = 32'h1 << (tbl[k] - 8'h30);
    idx = k;
    en = 1'b1;
    @(negedge mclk);
    chk(ln, l, "line");
    @(negedge mclk);
    chk(cr, exp_chan(l), "channel");
  endtask
  // strobe stays high across a burst so writes land on consecutive edges
  task wr_burst(input integer n);
    for (int q = 0; q < n; q++) begin
      r = $random(seed);
      assign_wr = 1'b1;
      assign_chan = r[3:0];
      assign_line = (q == 0) ? 5'h1f : r[8:4];
      m[r[3:0]] = assign_line;
      @(negedge mclk);
    end
    assign_wr = 1'b0;
    chk(rg, exp_regs(), "assign");
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    n_errors = 0;
    total_checks = 0;
    seed = 32'h93bc;
    {rst_n, en, assign_wr, idx, assign_chan, assign_line} = 0;
    for (i = 0; i < 16; i++)
      m[i] = i[4:0];
    repeat (20) @(negedge mclk);
    chk(cr, 16'h0, "reset channel");
    chk(rg, exp_regs(), "reset map");
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk(rg, exp_regs(), "default map");
    for (i = 0; i < 87; i++)
      probe(i[6:0]);
    for (j = 0; j < 8; j++) begin
      wr_burst(3);
      for (i = 0; i < 8; i++) begin
        r = $random(seed);
        probe(r[7:0] % 87);
      end
    end
    // mid-run reset must drop every remapped select back to its own index
    wr_burst(2);
    rst_n = 1'b0;
    @(negedge mclk);
    for (i = 0; i < 16; i++)
      m[i] = i[4:0];
    chk(rg, exp_regs(), "mid reset map");
    chk(cr, 16'h0, "mid reset channel");
    rst_n = 1'b1;
    for (i = 0; i < 4; i++)
      probe(i[6:0] + 7'h20);
    give_verdict;
  end
endmodule // testbench
